// [design/pia_pkg.sv]
// Constants, codes and carrier types of the prioritized interrupt arbiter.
package pia_pkg;
    localparam int PIA_NUM_SRC        = 86;
    localparam int PIA_NUM_FIXED      = 2;
    localparam int PIA_VEC_W          = 7;
    localparam int PIA_DATA_W         = 16;
    localparam int PIA_ADDR_W         = 6;
    localparam int PIA_CORE_ADDR_W    = 21;
    localparam int PIA_NUM_PRIO       = 11;
    localparam int PIA_FIELDS_PER_REG = 8;
    localparam int PIA_NUM_PEND       = 6;
    localparam int PIA_NUM_LEVELS     = 4;
    localparam int PIA_FAST_HI_W      = 5;

    localparam logic [5:0] PIA_OFF_PRIO0  = 6'h00;
    localparam logic [5:0] PIA_OFF_PRIO9  = 6'h09;
    localparam logic [5:0] PIA_OFF_VBASE  = 6'h0A;
    localparam logic [5:0] PIA_OFF_FIM0   = 6'h0B;
    localparam logic [5:0] PIA_OFF_FIVAL0 = 6'h0C;
    localparam logic [5:0] PIA_OFF_FIVAH0 = 6'h0D;
    localparam logic [5:0] PIA_OFF_FIM1   = 6'h0E;
    localparam logic [5:0] PIA_OFF_FIVAL1 = 6'h0F;
    localparam logic [5:0] PIA_OFF_FIVAH1 = 6'h10;
    localparam logic [5:0] PIA_OFF_PEND0  = 6'h11;
    localparam logic [5:0] PIA_OFF_PEND5  = 6'h16;
    localparam logic [5:0] PIA_OFF_STATUS = 6'h1D;
    localparam logic [5:0] PIA_OFF_PRIO10 = 6'h1F;

    // Index of the two documented priority registers and of the last of the eleven
    localparam int PIA_IDX_FLASH_PLL = 2;
    localparam int PIA_IDX_TIMER_D   = 6;
    localparam int PIA_IDX_LAST      = 10;

    localparam int PIA_FLD_FLASH_EMPTY = 14;
    localparam int PIA_FLD_FLASH_DONE  = 12;
    localparam int PIA_FLD_FLASH_ERR   = 10;
    localparam int PIA_FLD_PLL_UNLOCK  = 8;
    localparam int PIA_FLD_TD_CH3      = 12;
    localparam int PIA_FLD_TD_CH2      = 10;
    localparam int PIA_FLD_TD_CH1      = 8;
    localparam int PIA_FLD_TD_CH0      = 6;
    localparam int PIA_FLD_TD_RSVD     = 4;

    localparam logic [15:0] PIA_WMASK_FULL    = 16'hFFFF;
    localparam logic [15:0] PIA_WMASK_TIMER_D = 16'hFFCF;

    localparam logic [15:0] PIA_RST_PRIO  = 16'h0000;
    localparam logic [15:0] PIA_RST_VBASE = 16'h0000;
    localparam logic [6:0]  PIA_RST_FIM   = 7'h00;
    localparam logic [15:0] PIA_RST_FIVAL = 16'h0000;
    localparam logic [4:0]  PIA_RST_FIVAH = 5'h00;
    localparam logic [5:0]  PIA_BOOT_CYCLES = 6'h20;

    typedef enum logic [1:0] {
        PIA_CODE_OFF = 2'h0,
        PIA_CODE_L0  = 2'h1,
        PIA_CODE_L1  = 2'h2,
        PIA_CODE_L2  = 2'h3
    } pia_code_t;

    localparam logic [1:0] PIA_LVL_FIXED = 2'h3;

    typedef enum logic [1:0] {
        PIA_ST_BOOT = 2'b01,
        PIA_ST_RUN  = 2'b10
    } pia_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [15:0] wdata;
    } pia_bus_t;

    typedef struct packed {
        logic        irq;
        logic        fast;
        logic [1:0]  level;
        logic [6:0]  vec;
        logic [20:0] addr;
    } pia_core_t;
endpackage : pia_pkg

// [design/pia_lowest_first.sv]
// Finds the lowest-numbered active request of one priority level.
`timescale 1ns/1ps
module pia_lowest_first #(
    parameter int WIDTH = 86,
    parameter int IDX_W = 7
) (
    input  wire logic [WIDTH-1:0] req_in,
    output logic                  any_out,
    output logic [IDX_W-1:0]      idx_out
);
    always_comb begin
        any_out = 1'b0;
        idx_out = '0;
        // Walk downward so the smallest set index is the last one kept
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (req_in[i]) begin
                any_out = 1'b1;
                idx_out = IDX_W'(i);
            end
        end
    end
endmodule : pia_lowest_first

// [design/pia_arbiter.sv]
// Prioritized interrupt arbiter: registers, level arbitration and vectoring.
//
// Summary of operation
// - Accept 86 request sources; four levels, programmable except a few fixed ones.
// - Inside one level the lowest source number wins; source 0 highest.
// - Normal vector address is vector base concatenated with vector number.
// - Core mask 00..11 permits levels from mask value up to level 3.
// - Two-bit field: 00 off, 01 level 0, 10 level 1, 11 level 2.
// - Flash/PLL register: buffers empty 15-14, command done 13-12, error 11-10.
// - Same register holds PLL unlock level in bits 9-8.
// - Timer D register: ch3 13-12, ch2 11-10, ch1 9-8, ch0 7-6.
// - Timer D register bits 5-4 read zero and ignore writes.
// - Signal core when a serviceable request exists, with its jump address.
// - Tell the system integration module to restart clocks in Wait or Stop.
// - After reset drive the initial fetch address onto the core address bus.
// - Two independently programmable fast interrupt channels.
// - Registers are a slave on the peripheral bus, master reads and writes.
// - Priority registers 0-9 at 0x0-0x9, vector base at 0xA.
// - Six pending request registers at 0x11 through 0x16.
`timescale 1ns/1ps
module pia_arbiter
    import pia_pkg::*;
#(
    parameter logic [20:0] RESET_ADDR = 21'h000000
) (
    input  wire logic                   clk_in,
    input  wire logic                   rst_b_in,
    input  wire pia_bus_t               bus_in,
    output logic [PIA_DATA_W-1:0]       bus_rdata_out,
    input  wire logic [PIA_NUM_SRC-1:0] irq_src_in,
    input  wire logic [1:0]             core_mask_bits_in,
    input  wire logic                   low_power_in,
    output pia_core_t                   core_out,
    output logic                        wake_out,
    output logic [PIA_CORE_ADDR_W-1:0]  fetch_addr_out,
    output logic                        fetch_drive_out
);
    logic [15:0]      prio_reg [PIA_NUM_PRIO];
    logic [15:0]      vector_base;
    logic [6:0]       fim [2];
    logic [15:0]      fival [2];
    logic [4:0]       fivah [2];
    logic [PIA_NUM_SRC-1:0] src_en;
    logic [1:0]       src_lvl [PIA_NUM_SRC];
    logic [PIA_NUM_SRC-1:0] lvl_req [PIA_NUM_LEVELS];
    logic [PIA_NUM_LEVELS-1:0] lvl_any;
    logic [6:0]       lvl_idx [PIA_NUM_LEVELS];
    logic             next_irq;
    logic [1:0]       next_level;
    logic [6:0]       next_vec;
    logic             next_fast;
    logic [20:0]      next_addr;
    logic [15:0]      next_rdata;
    logic [3:0]       wr_prio_idx;
    logic             wr_prio_hit;
    logic [95:0]      pend_wide;
    logic [2:0]       pend_sel;
    pia_state_t       state;
    logic [5:0]       boot_cnt;
    logic [127:0]     en_wide;
    logic [127:0]     req_wide;

    assign pend_wide = 96'(irq_src_in);
    assign en_wide   = 128'(src_en);
    assign req_wide  = 128'(irq_src_in);
    assign pend_sel  = 3'(bus_in.addr - PIA_OFF_PEND0);

    // Source to field map; fixed sources sit at the top level
    genvar s;
    generate
        for (s = 0; s < PIA_NUM_SRC; s++) begin : g_src
            if (s < PIA_NUM_FIXED) begin : g_fixed
                assign src_en[s]  = 1'b1;
                assign src_lvl[s] = PIA_LVL_FIXED;
            end else begin : g_prog
                localparam int K   = s - PIA_NUM_FIXED;
                localparam int RI  = K / PIA_FIELDS_PER_REG;
                localparam int LO  = 2 * (PIA_FIELDS_PER_REG - 1 - (K % PIA_FIELDS_PER_REG));
                logic [1:0] code;
                assign code       = prio_reg[RI][LO +: 2];
                assign src_en[s]  = (code != PIA_CODE_OFF);
                assign src_lvl[s] = 2'(code - 2'h1);
            end
        end
    endgenerate

    genvar l;
    generate
        for (l = 0; l < PIA_NUM_LEVELS; l++) begin : g_lvl
            always_comb begin
                for (int i = 0; i < PIA_NUM_SRC; i++) begin
                    lvl_req[l][i] = irq_src_in[i] & src_en[i] & (src_lvl[i] == 2'(l));
                end
            end
            pia_lowest_first #(
                .WIDTH (PIA_NUM_SRC),
                .IDX_W (PIA_VEC_W)
            ) u_enc (
                .req_in  (lvl_req[l]),
                .any_out (lvl_any[l]),
                .idx_out (lvl_idx[l])
            );

            property p_lowest_wins;
                @(posedge clk_in) disable iff (!rst_b_in)
                lvl_any[l] |->
                    ((lvl_req[l] & ((86'h1 << lvl_idx[l]) - 86'h1)) == '0) && lvl_req[l][lvl_idx[l]];
            endproperty
            a_lowest_wins: assert property (p_lowest_wins) else $error("lower source skipped");
        end
    endgenerate

    // Level choice: later (higher) permitted levels override earlier ones
    always_comb begin
        next_irq   = 1'b0;
        next_level = 2'h0;
        next_vec   = 7'h00;
        for (int i = 0; i < PIA_NUM_LEVELS; i++) begin
            if (lvl_any[i] && (2'(i) >= core_mask_bits_in)) begin
                next_irq   = 1'b1;
                next_level = 2'(i);
                next_vec   = lvl_idx[i];
            end
        end
        next_fast = next_irq && ((next_vec == fim[0]) || (next_vec == fim[1]));
        if (next_irq && next_vec == fim[0]) begin
            next_addr = {fivah[0], fival[0]};
        end else if (next_irq && next_vec == fim[1]) begin
            next_addr = {fivah[1], fival[1]};
        end else begin
            next_addr = {vector_base[13:0], next_vec};
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            core_out <= '0;
        end else begin
            core_out.irq   <= next_irq;
            core_out.fast  <= next_fast;
            core_out.level <= next_level;
            core_out.vec   <= next_vec;
            core_out.addr  <= next_addr;
        end
    end

    // Wake ignores the core mask: any enabled request restarts clocks
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wake_out <= 1'b0;
        end else begin
            wake_out <= low_power_in && (lvl_any != '0);
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state           <= PIA_ST_BOOT;
            boot_cnt        <= '0;
            fetch_drive_out <= 1'b1;
            fetch_addr_out  <= RESET_ADDR;
        end else begin
            case (state)
                PIA_ST_BOOT: begin
                    fetch_drive_out <= 1'b1;
                    fetch_addr_out  <= RESET_ADDR;
                    boot_cnt        <= 6'(boot_cnt + 6'h01);
                    if (boot_cnt == PIA_BOOT_CYCLES - 6'h01) begin
                        state           <= PIA_ST_RUN;
                        fetch_drive_out <= 1'b0;
                    end
                end
                PIA_ST_RUN: begin
                    fetch_drive_out <= 1'b0;
                end
                default: begin
                    state <= PIA_ST_BOOT;
                end
            endcase
        end
    end

    // Priority register write decode
    always_comb begin
        wr_prio_hit = 1'b0;
        wr_prio_idx = 4'h0;
        if (bus_in.addr <= PIA_OFF_PRIO9) begin
            wr_prio_hit = bus_in.wr;
            wr_prio_idx = bus_in.addr[3:0];
        end else if (bus_in.addr == PIA_OFF_PRIO10) begin
            wr_prio_hit = bus_in.wr;
            wr_prio_idx = 4'(PIA_IDX_LAST);
        end
    end

    generate
        for (l = 0; l < PIA_NUM_PRIO; l++) begin : g_prio
            localparam logic [15:0] WMASK =
                (l == PIA_IDX_TIMER_D) ? PIA_WMASK_TIMER_D : PIA_WMASK_FULL;
            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    prio_reg[l] <= PIA_RST_PRIO;
                end else if (wr_prio_hit && wr_prio_idx == 4'(l)) begin
                    prio_reg[l] <= bus_in.wdata & WMASK;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            vector_base <= PIA_RST_VBASE;
            fim[0]      <= PIA_RST_FIM;
            fim[1]      <= PIA_RST_FIM;
            fival[0]    <= PIA_RST_FIVAL;
            fival[1]    <= PIA_RST_FIVAL;
            fivah[0]    <= PIA_RST_FIVAH;
            fivah[1]    <= PIA_RST_FIVAH;
        end else if (bus_in.wr) begin
            case (bus_in.addr)
                PIA_OFF_VBASE:  vector_base <= bus_in.wdata;
                PIA_OFF_FIM0:   fim[0]      <= bus_in.wdata[6:0];
                PIA_OFF_FIVAL0: fival[0]    <= bus_in.wdata;
                PIA_OFF_FIVAH0: fivah[0]    <= bus_in.wdata[4:0];
                PIA_OFF_FIM1:   fim[1]      <= bus_in.wdata[6:0];
                PIA_OFF_FIVAL1: fival[1]    <= bus_in.wdata;
                PIA_OFF_FIVAH1: fivah[1]    <= bus_in.wdata[4:0];
                default: begin
                end
            endcase
        end
    end

    // Read mux; pending and status words are read-only
    always_comb begin
        next_rdata = 16'h0000;
        if (bus_in.addr <= PIA_OFF_PRIO9) begin
            next_rdata = prio_reg[bus_in.addr[3:0]];
        end else if (bus_in.addr >= PIA_OFF_PEND0 && bus_in.addr <= PIA_OFF_PEND5) begin
            next_rdata = pend_wide[16 * pend_sel +: 16];
        end else begin
            case (bus_in.addr)
                PIA_OFF_VBASE:  next_rdata = vector_base;
                PIA_OFF_FIM0:   next_rdata = {9'h000, fim[0]};
                PIA_OFF_FIVAL0: next_rdata = fival[0];
                PIA_OFF_FIVAH0: next_rdata = {11'h000, fivah[0]};
                PIA_OFF_FIM1:   next_rdata = {9'h000, fim[1]};
                PIA_OFF_FIVAL1: next_rdata = fival[1];
                PIA_OFF_FIVAH1: next_rdata = {11'h000, fivah[1]};
                PIA_OFF_STATUS: next_rdata = {core_out.irq, core_out.fast, core_out.level,
                                              5'h00, core_out.vec};
                PIA_OFF_PRIO10: next_rdata = prio_reg[PIA_IDX_LAST];
                default:        next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bus_rdata_out <= 16'h0000;
        end else if (bus_in.rd) begin
            bus_rdata_out <= next_rdata;
        end
    end

    property p_resv_zero;
        @(posedge clk_in) disable iff (!rst_b_in)
        bus_in.rd && bus_in.addr == 6'(PIA_IDX_TIMER_D) |=> bus_rdata_out[5:4] == 2'h0;
    endproperty
    a_resv_zero: assert property (p_resv_zero) else $error("reserved bits not zero");

    property p_mask_honoured;
        @(posedge clk_in) disable iff (!rst_b_in)
        core_out.irq |-> core_out.level >= $past(core_mask_bits_in);
    endproperty
    a_mask_honoured: assert property (p_mask_honoured) else $error("masked level sent");

    property p_normal_vector;
        @(posedge clk_in) disable iff (!rst_b_in)
        core_out.irq && !core_out.fast |->
            core_out.addr == {$past(vector_base[13:0]), core_out.vec};
    endproperty
    a_normal_vector: assert property (p_normal_vector) else $error("bad vector address");

    property p_disabled_silent;
        @(posedge clk_in) disable iff (!rst_b_in)
        next_irq |-> en_wide[next_vec] && req_wide[next_vec];
    endproperty
    a_disabled_silent: assert property (p_disabled_silent) else $error("disabled source won");

    property p_top_level_first;
        @(posedge clk_in) disable iff (!rst_b_in)
        core_out.irq |-> ($past(lvl_any) >> (core_out.level + 3'h1)) == '0
            || core_out.level == 2'h3;
    endproperty
    a_top_level_first: assert property (p_top_level_first) else $error("lower level chosen");

    property p_signal_core;
        @(posedge clk_in) disable iff (!rst_b_in)
        lvl_any[3] |=> core_out.irq && core_out.level == 2'h3;
    endproperty
    a_signal_core: assert property (p_signal_core) else $error("request not signalled");

    property p_wake;
        @(posedge clk_in) disable iff (!rst_b_in)
        low_power_in && (lvl_any != '0) |=> wake_out ##1 1'b1;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake notice");

    property p_boot_addr;
        @(posedge clk_in) disable iff (!rst_b_in)
        state == PIA_ST_BOOT |-> fetch_drive_out && fetch_addr_out == RESET_ADDR;
    endproperty
    a_boot_addr: assert property (p_boot_addr) else $error("boot address missing");

    property p_fast_match;
        @(posedge clk_in) disable iff (!rst_b_in)
        core_out.fast |-> core_out.irq &&
            (core_out.vec == $past(fim[0]) || core_out.vec == $past(fim[1]));
    endproperty
    a_fast_match: assert property (p_fast_match) else $error("fast without match");

    property p_vbase_write;
        @(posedge clk_in) disable iff (!rst_b_in)
        bus_in.wr && bus_in.addr == PIA_OFF_VBASE |=> vector_base == $past(bus_in.wdata);
    endproperty
    a_vbase_write: assert property (p_vbase_write) else $error("vector base not written");
endmodule : pia_arbiter

// [testbench/pia_core_model.sv]
// Core-side stand-in: supplies mask and sleep state, counts boot fetch cycles.
`timescale 1ns/1ps
module pia_core_model (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic [1:0] mask_cmd_in,
    input  wire logic       sleep_cmd_in,
    input  wire logic       fetch_drive_in,
    output logic [1:0]      core_mask_bits_out,
    output logic            low_power_out,
    output logic [7:0]      boot_len_out
);
    assign core_mask_bits_out = mask_cmd_in;
    assign low_power_out      = sleep_cmd_in;
    // Counts edges that see the boot address still driven
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            boot_len_out <= 8'h00;
        end else if (fetch_drive_in) begin
            boot_len_out <= boot_len_out + 8'h01;
        end
    end
endmodule : pia_core_model

// [testbench/prioritized_irq_arbiter_test.sv]
// Self-checking testbench of the prioritized interrupt arbiter.
`timescale 1ns/1ps
module prioritized_irq_arbiter_test;
    import pia_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    pia_bus_t    bus_in = '0;
    logic [15:0] bus_rdata_out;
    logic [85:0] irq_src_in = '0;
    logic [1:0]  mask_cmd = 2'h0;
    logic        sleep_cmd = 1'b0;
    logic [1:0]  core_mask_bits_in;
    logic        low_power_in;
    pia_core_t   core_out;
    logic        wake_out;
    logic        fetch_drive_out;
    logic [20:0] fetch_addr_out;
    logic [7:0]  boot_len;
    logic [15:0] prio [0:10];
    logic [15:0] vbase;
    logic [6:0]  fim [0:1];
    logic [20:0] fadr [0:1];
    logic [15:0] rdv;
    logic [95:0] pend;
    int          failures = 0;
    int          n_compared = 0;

    always #20 clk_in = ~clk_in;

    pia_arbiter dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus_in(bus_in),
        .bus_rdata_out(bus_rdata_out), .irq_src_in(irq_src_in),
        .core_mask_bits_in(core_mask_bits_in), .low_power_in(low_power_in),
        .core_out(core_out), .wake_out(wake_out), .fetch_addr_out(fetch_addr_out),
        .fetch_drive_out(fetch_drive_out));
    pia_core_model core (.clk_in(clk_in), .rst_b_in(rst_b_in), .mask_cmd_in(mask_cmd),
        .sleep_cmd_in(sleep_cmd), .fetch_drive_in(fetch_drive_out),
        .core_mask_bits_out(core_mask_bits_in), .low_power_out(low_power_in),
        .boot_len_out(boot_len));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    // Strobe held a full cycle, then an idle cycle so it never toggles twice at one edge
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        bus_in = '{1'b1, 1'b0, a, d};
        @(negedge clk_in);
        bus_in.wr = 1'b0;
        @(negedge clk_in);
        case (a)
            6'h06:          prio[6] = d & PIA_WMASK_TIMER_D;
            PIA_OFF_PRIO10: prio[10] = d;
            PIA_OFF_VBASE:  vbase = d;
            PIA_OFF_FIM0:   fim[0] = d[6:0];
            PIA_OFF_FIM1:   fim[1] = d[6:0];
            PIA_OFF_FIVAL0: fadr[0][15:0] = d;
            PIA_OFF_FIVAL1: fadr[1][15:0] = d;
            PIA_OFF_FIVAH0: fadr[0][20:16] = d[4:0];
            PIA_OFF_FIVAH1: fadr[1][20:16] = d[4:0];
            default: if (a <= PIA_OFF_PRIO9) prio[a] = d;
        endcase
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        bus_in.rd = 1'b1;
        bus_in.addr = a;
        @(negedge clk_in);
        d = bus_rdata_out;
        bus_in.rd = 1'b0;
        @(negedge clk_in);
    endtask : rd

    // Enable bit and level of one source
    function automatic logic [2:0] lvl_of(input int s);
        logic [1:0] c;
        if (s < 2) return 3'b111;
        c = prio[(s - 2) / 8][2 * (7 - (s - 2) % 8) +: 2];
        return (c == 2'h0) ? 3'b000 : {1'b1, c - 2'h1};
    endfunction : lvl_of

    function automatic pia_core_t expect_core(input logic [85:0] src, input logic [1:0] m);
        pia_core_t  e;
        logic [2:0] l;
        e = '0;
        for (int lv = 3; lv >= int'(m); lv--) begin
            for (int s = 0; s < 86; s++) begin
                l = lvl_of(s);
                if (!e.irq && src[s] && l[2] && int'(l[1:0]) == lv) begin
                    e.irq = 1'b1;
                    e.level = l[1:0];
                    e.vec = 7'(s);
                end
            end
        end
        e.fast = e.irq && (e.vec == fim[0] || e.vec == fim[1]);
        e.addr = e.fast ? (e.vec == fim[0] ? fadr[0] : fadr[1]) : {vbase[13:0], e.vec};
        return e;
    endfunction : expect_core

    function automatic logic expect_wake(input logic [85:0] src, input logic lp);
        logic w;
        w = 1'b0;
        for (int s = 0; s < 86; s++) begin
            w |= src[s] && lvl_of(s) >= 3'b100;
        end
        return w && lp;
    endfunction : expect_wake

    task automatic apply(input logic [85:0] src, input logic [1:0] m, input logic lp);
        pia_core_t e;
        irq_src_in = src;
        mask_cmd = m;
        sleep_cmd = lp;
        @(negedge clk_in);
        e = expect_core(src, m);
        cmp(core_out.irq, e.irq, "irq");
        cmp(wake_out, expect_wake(src, lp), "wake");
        if (e.irq) begin
            cmp(core_out.vec, e.vec, "vector");
            cmp(core_out.level, e.level, "level");
            cmp(core_out.fast, e.fast, "fast");
            cmp(core_out.addr, e.addr, "address");
        end
    endtask : apply

    function automatic logic [85:0] rnd_src;
        logic [95:0] r;
        r = {$urandom, $urandom, $urandom} & {$urandom, $urandom, $urandom};
        return r[85:0] & 86'({$urandom, $urandom, $urandom});
    endfunction : rnd_src

    initial begin
        #2_000_000;
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        rdv = 16'($urandom(4));
        for (int i = 0; i < 11; i++) prio[i] = 16'h0000;
        vbase = 16'h0000;
        fim = '{7'h00, 7'h00};
        fadr = '{21'h000000, 21'h000000};
        repeat (12) @(negedge clk_in);
        rst_b_in = 1'b1;
        cmp(fetch_drive_out, 1'b1, "boot drive");
        cmp(fetch_addr_out, 21'h000000, "boot address");
        for (int i = 0; i < 10; i++) begin
            rd(6'(i), rdv);
            cmp(rdv, 16'h0000, "priority reset");
        end
        rd(PIA_OFF_VBASE, rdv);
        cmp(rdv, 16'h0000, "base reset");
        repeat (40) @(negedge clk_in);
        cmp(boot_len, 8'(PIA_BOOT_CYCLES), "boot length");
        cmp(fetch_drive_out, 1'b0, "boot drive released");
        $display("test reset done");

        wr(6'h02, 16'hFFFF);
        wr(6'h06, 16'hFFFF);
        wr(PIA_OFF_PEND0, 16'hFFFF);
        rd(6'h02, rdv);
        cmp(rdv, 16'hFFFF, "flash and pll register");
        rd(6'h06, rdv);
        cmp(rdv, 16'hFFCF, "timer register");
        rd(6'h30, rdv);
        cmp(rdv, 16'h0000, "unmapped");
        wr(PIA_OFF_PRIO10, 16'hA5A5);
        rd(PIA_OFF_PRIO10, rdv);
        cmp(rdv, 16'hA5A5, "last priority register");
        irq_src_in = rnd_src();
        pend = {10'h000, irq_src_in};
        for (int w = 0; w < 6; w++) begin
            rd(PIA_OFF_PEND0 + 6'(w), rdv);
            cmp(rdv, pend[16 * w +: 16], "pending");
        end
        $display("test register map done");

        // One field at a time, so a misplaced field shows as a wrong vector
        for (int f = 0; f < 4; f++) begin
            wr(6'h02, 16'h4000 >> (2 * f));
            apply(86'hF << 18, 2'h0, 1'b1);
            wr(6'h06, 16'h1000 >> (2 * f));
            apply(86'h1F << 51, 2'h0, 1'b1);
        end
        for (int c = 0; c < 4; c++) begin
            wr(6'h02, 16'(c) << 14);
            for (int m = 0; m < 4; m++) apply(86'h1 << 18, 2'(m), 1'b1);
        end
        $display("test fields done");

        wr(6'h02, 16'hFF00);
        wr(PIA_OFF_FIM0, 16'h0014);
        wr(PIA_OFF_FIM1, 16'h0014);
        wr(PIA_OFF_FIVAL0, 16'h1234);
        wr(PIA_OFF_FIVAH0, 16'h0015);
        wr(PIA_OFF_FIVAL1, 16'hABCD);
        wr(PIA_OFF_FIVAH1, 16'h000A);
        apply(86'h1 << 20, 2'h0, 1'b0);
        rd(PIA_OFF_STATUS, rdv);
        cmp(rdv, 16'hE014, "status word");
        $display("test fast done");

        for (int it = 0; it < 150; it++) begin
            for (int i = 0; i < 10; i++) wr(6'(i), 16'($urandom));
            wr(PIA_OFF_PRIO10, 16'($urandom));
            wr(PIA_OFF_VBASE, 16'($urandom));
            wr(PIA_OFF_FIM0, 16'($urandom_range(0, 85)));
            wr(PIA_OFF_FIM1, 16'($urandom_range(0, 85)));
            wr(PIA_OFF_FIVAL1, 16'($urandom));
            for (int j = 0; j < 4; j++) begin
                apply(rnd_src() & ~86'(j == 0 ? 3 : 0), 2'($urandom), 1'($urandom));
            end
        end
        apply(86'h0, 2'h0, 1'b1);
        $display("test random done");
        wrap_up();
    end
endmodule : prioritized_irq_arbiter_test
